// File: common/lmac_map.svh
/*
  Lower MAC constants: short register offsets, field positions,
  reset values and timing figures.
  Assumes inclusion by bare name from any file that needs it.
*/
`ifndef LMAC_MAP_SVH
`define LMAC_MAP_SVH
// ==========================================
// short register offsets
`define LMAC_A_HSYM_LO   6'h28
`define LMAC_A_HSYM_HI   6'h29
`define LMAC_A_CCA_CTL   6'h3A
`define LMAC_A_ED_THR    6'h3F
// ==========================================
// field positions
`define LMAC_CCA_MODE_HI 7
`define LMAC_CCA_MODE_LO 6
`define LMAC_CS_THR_HI   5
`define LMAC_CS_THR_LO   2
`define LMAC_FCF_SEC     3
`define LMAC_FCF_PEND    4
`define LMAC_FCF_ACKREQ  5
`define LMAC_FCF_INTRA   6
`define LMAC_FCF_DAM_HI  11
`define LMAC_FCF_DAM_LO  10
`define LMAC_FCF_SAM_HI  15
`define LMAC_FCF_SAM_LO  14
// ==========================================
// reset values and codes
`define LMAC_RST_HSYM    8'h00
`define LMAC_RST_CCA_CTL 8'h78
`define LMAC_RST_ED_THR  8'h00
`define LMAC_CCA_CS      2'h1
`define LMAC_CCA_ED      2'h2
`define LMAC_CCA_BOTH    2'h3
`define LMAC_DAM_SHORT   2'h2
`define LMAC_BCAST       16'hFFFF
`define LMAC_CRC_POLY    16'h8408
`define LMAC_NSLOT       5'd16
`define LMAC_MIN_CAP_END 4'h8
// ==========================================
// timing
`define LMAC_HSYM_NS     8000
`define LMAC_CLK_NS      5
`endif

// File: common/lmac_pkg.sv
/*
  Lower MAC types: register request, byte stream carrier, modes
  and state enumerations.
  Assumes nothing beyond a SystemVerilog compiler.
*/
package lmac_pkg;
  typedef struct packed {
    logic       we;
    logic       re;
    logic [5:0] addr;
    logic [7:0] wdata;
  } lmac_reg_req_t;

  typedef struct packed {
    logic       valid;
    logic       last;
    logic [7:0] data;
  } lmac_byte_t;

  typedef enum logic [1:0] {
    LMAC_RXM_NORMAL, LMAC_RXM_PROMISC, LMAC_RXM_ERROR, LMAC_RXM_RSVD
  } lmac_rxmode_t;

  typedef enum logic [1:0] {
    LMAC_PER_BEACON, LMAC_PER_CAP, LMAC_PER_CFP, LMAC_PER_INACT
  } lmac_period_t;

  typedef enum logic [1:0] {
    LMAC_FIFO_BEACON, LMAC_FIFO_NORMAL, LMAC_FIFO_GTS1, LMAC_FIFO_GTS2
  } lmac_fifo_t;
endpackage

// File: rtl/lmac_crc16.sv
/*
  Serial-equivalent CRC-16 over one byte per cycle, LSB first.
  Assumes the caller clears it before each frame.
*/
`timescale 1ns/1ps
`default_nettype none
`include "lmac_map.svh"
module lmac_crc16 (
  input  wire logic        clk,
  input  wire logic        rst_n,
  input  wire logic        clr,
  input  wire logic        en,
  input  wire logic [7:0]  din,
  output var  logic [15:0] crc_q
);
  // ==========================================
  // byte step of x^16+x^12+x^5+1, reflected
  function automatic logic [15:0] step(input logic [15:0] c,
                                       input logic [7:0] d);
    logic [15:0] r;
    r = c;
    for (int i = 0; i < 8; i++) begin
      if (r[0] ^ d[i]) begin
        r = (r >> 1) ^ `LMAC_CRC_POLY;
      end else begin
        r = r >> 1;
      end
    end
    return r;
  endfunction

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      crc_q <= 16'h0000;
    end else if (clr) begin
      crc_q <= 16'h0000;
    end else if (en) begin
      crc_q <= step(crc_q, din);
    end
  end
endmodule
`default_nettype wire

// File: rtl/lmac_rxbuf.sv
/*
  Receive frame buffer: one write port, one registered read port.
  Assumes addresses stay below DEPTH.
*/
`timescale 1ns/1ps
`default_nettype none
module lmac_rxbuf #(
  parameter int DEPTH = 144,
  parameter int AW    = 8
) (
  input  wire logic          clk,
  input  wire logic          we,
  input  wire logic [AW-1:0] waddr,
  input  wire logic [7:0]    wdata,
  input  wire logic [AW-1:0] raddr,
  output var  logic [7:0]    rdata_q
);
  logic [7:0] mem [DEPTH];

  always_ff @(posedge clk) begin
    if (we) begin
      mem[waddr] <= wdata;
    end
  end

  always_ff @(posedge clk) begin
    rdata_q <= mem[raddr];
  end
endmodule
`default_nettype wire

// File: rtl/lmac_top.sv
/*
  Lower MAC: CCA decision, receive store/filter/ack, transmit FCS
  append, superframe scheduling and the half-symbol MAC timer.
  Assumes baseband and host inputs synchronous to CLK; the length
  byte arrives first on the receive stream.
*/
// How it works
// RULE1: stored frame: length, header, payload, two FCS, LQI, RSSI.
// RULE2: mode 01 uses carrier sense against bits 5-2 of 0x3A.
// RULE3: mode 10 uses energy detection against register 0x3F.
// RULE4: mode 11 checks both carrier sense and energy results.
// RULE5: transmit path appends a 16-bit FCS by itself.
// RULE6: FCS is CRC-16 with polynomial x^16+x^12+x^5+1.
// RULE7: beacon in beacon period, normal in CAP, GTS in CFP.
// RULE8: received bytes are stored while the FCS is checked.
// RULE9: normal mode interrupts only on PAN, address and FCS match.
// RULE10: normal mode drops failing frames silently.
// RULE11: promiscuous mode accepts every frame with good FCS.
// RULE12: error mode accepts every frame.
// RULE13: accepted good frame with ack request triggers an ack.
// RULE14: frame control bits parsed into type, flags and modes; the code decodes only the ack request flag and destination addressing mode.
// RULE15: 16-bit timer counts down once per 8 us.
// RULE16: writing the high byte starts the timer.
// RULE17: timer reaching zero raises the half-symbol interrupt.
// RULE18: timer bytes at 0x28 and 0x29, read/write, reset zero.
// RULE19: host loads 1920 ticks for 15.36 ms.
// RULE20: active period has 16 slots, CAP at least nine; the code forces the CAP to at least eight slots.
// RULE21: back-offs in CAP align to slot boundaries.
// RULE22: no CSMA-CA during a guaranteed time slot.
// RULE23: start loads count from new high and stored low byte.
`timescale 1ns/1ps
`default_nettype none
`include "lmac_map.svh"
module lmac_top import lmac_pkg::*; #(
  parameter int RXDEPTH = 144,
  parameter int RXAW    = 8
) (
  // clock and reset
  input  wire logic            CLK,
  input  wire logic            RST_N,
  // short register port
  input  wire lmac_reg_req_t   REG_REQ,
  output var  logic [7:0]      REG_RDATA,
  // baseband receive and channel metrics
  input  wire lmac_byte_t      RXB,
  input  wire logic            RXB_SOF,
  input  wire logic [7:0]      RXB_LQI,
  input  wire logic [7:0]      RXB_RSSI,
  input  wire logic [3:0]      CS_LEVEL,
  input  wire logic [7:0]      ED_LEVEL,
  output var  logic            CCA_BUSY,
  // identity and receive mode
  input  wire lmac_rxmode_t    RX_MODE,
  input  wire logic [15:0]     OWN_PAN,
  input  wire logic [15:0]     OWN_ADDR,
  // host side of the frame buffer
  input  wire logic [RXAW-1:0] RXBUF_RADDR,
  output var  logic [7:0]      RXBUF_RDATA,
  output var  logic            RX_IRQ,
  output var  logic            ACK_REQ,
  output var  logic [7:0]      ACK_SEQ,
  // transmit stream
  input  wire lmac_byte_t      TXI,
  output var  logic            TXI_READY,
  output var  lmac_byte_t      TXO,
  // superframe
  input  wire logic            SF_BEACON,
  input  wire logic            SF_SLOT_TICK,
  input  wire logic [3:0]      SF_CAP_END,
  input  wire logic [3:0]      SF_GTS2_START,
  output var  lmac_period_t    SF_PERIOD,
  output var  lmac_fifo_t      TX_FIFO_SEL,
  output var  logic            CSMA_EN,
  output var  logic            BACKOFF_ALIGN,
  // timer
  output var  logic            HSYM_IRQ
);
  localparam int HSYM_CYC = `LMAC_HSYM_NS / `LMAC_CLK_NS;

  // ==========================================
  // short registers
  logic [7:0]  tmr_lo_q, tmr_hi_q, cca_ctl_q, ed_thr_q;
  logic [15:0] tcnt_q;
  logic        trun_q;
  wire logic   wr_hi = REG_REQ.we && REG_REQ.addr == `LMAC_A_HSYM_HI;

  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      tmr_lo_q  <= `LMAC_RST_HSYM;
      tmr_hi_q  <= `LMAC_RST_HSYM;
      cca_ctl_q <= `LMAC_RST_CCA_CTL;
      ed_thr_q  <= `LMAC_RST_ED_THR;
    end else if (REG_REQ.we) begin
      unique case (REG_REQ.addr)
        `LMAC_A_HSYM_LO: tmr_lo_q  <= REG_REQ.wdata; // RULE18
        `LMAC_A_HSYM_HI: tmr_hi_q  <= REG_REQ.wdata; // RULE18
        `LMAC_A_CCA_CTL: cca_ctl_q <= REG_REQ.wdata;
        `LMAC_A_ED_THR:  ed_thr_q  <= REG_REQ.wdata;
        default: ;
      endcase
    end
  end

  // timer bytes read back the live count while it runs
  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      REG_RDATA <= 8'h00;
    end else if (REG_REQ.re) begin
      unique case (REG_REQ.addr)
        `LMAC_A_HSYM_LO: REG_RDATA <= trun_q ? tcnt_q[7:0] : tmr_lo_q;
        `LMAC_A_HSYM_HI: REG_RDATA <= trun_q ? tcnt_q[15:8] : tmr_hi_q;
        `LMAC_A_CCA_CTL: REG_RDATA <= cca_ctl_q;
        `LMAC_A_ED_THR:  REG_RDATA <= ed_thr_q;
        default:         REG_RDATA <= 8'h00;
      endcase
    end
  end

  // ==========================================
  // half-symbol timer
  logic [10:0] tick_q;
  wire logic   tick = tick_q == 11'(HSYM_CYC - 1);

  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      tick_q <= 11'h000;
    end else if (wr_hi || tick) begin
      tick_q <= 11'h000; // RULE15
    end else begin
      tick_q <= tick_q + 11'h001;
    end
  end

  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      tcnt_q   <= 16'h0000;
      trun_q   <= 1'b0;
      HSYM_IRQ <= 1'b0;
    end else begin
      HSYM_IRQ <= 1'b0;
      if (wr_hi) begin
        tcnt_q <= {REG_REQ.wdata, tmr_lo_q}; // RULE23
        trun_q <= 1'b1; // RULE16
      end else if (trun_q && tick) begin
        tcnt_q <= tcnt_q - 16'h0001; // RULE15
        if (tcnt_q <= 16'h0001) begin
          // a zero load must not wrap to all ones
          tcnt_q   <= 16'h0000;
          trun_q   <= 1'b0;
          HSYM_IRQ <= 1'b1; // RULE17
        end
      end
    end
  end

  // ==========================================
  // clear channel assessment
  wire logic [1:0] cca_mode =
    cca_ctl_q[`LMAC_CCA_MODE_HI:`LMAC_CCA_MODE_LO];
  wire logic cs_busy =
    CS_LEVEL >= cca_ctl_q[`LMAC_CS_THR_HI:`LMAC_CS_THR_LO];
  wire logic ed_busy = ED_LEVEL >= ed_thr_q;

  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      CCA_BUSY <= 1'b0;
    end else begin
      unique case (cca_mode)
        `LMAC_CCA_CS:   CCA_BUSY <= cs_busy; // RULE2
        `LMAC_CCA_ED:   CCA_BUSY <= ed_busy; // RULE3
        `LMAC_CCA_BOTH: CCA_BUSY <= cs_busy || ed_busy; // RULE4
        default:        CCA_BUSY <= 1'b0;
      endcase
    end
  end

  // ==========================================
  // receive: store, check and filter
  typedef enum logic [1:0] {RX_IDLE, RX_BODY, RX_LQI, RX_RSSI} rx_st_t;
  rx_st_t          rx_q;
  logic [RXAW-1:0] waddr_q;
  logic [6:0]      left_q, idx_q;
  logic [15:0]     fcf_q, dpan_q, daddr_q, rx_crc;
  logic [7:0]      seq_q, wdat;
  logic            we;
  wire logic       body_b = rx_q == RX_BODY && RXB.valid;

  always_comb begin
    we   = 1'b0;
    wdat = RXB.data;
    unique case (rx_q)
      RX_IDLE: we = RXB.valid && RXB_SOF; // RULE1
      RX_BODY: we = RXB.valid; // RULE8
      RX_LQI: begin
        we   = 1'b1;
        wdat = RXB_LQI; // RULE1
      end
      RX_RSSI: begin
        we   = 1'b1;
        wdat = RXB_RSSI; // RULE1
      end
    endcase
  end

  lmac_rxbuf #(.DEPTH(RXDEPTH), .AW(RXAW)) u_rxbuf (
    .clk     (CLK),
    .we      (we),
    .waddr   (waddr_q),
    .wdata   (wdat),
    .raddr   (RXBUF_RADDR),
    .rdata_q (RXBUF_RDATA)
  );

  lmac_crc16 u_rxcrc (
    .clk   (CLK),
    .rst_n (RST_N),
    .clr   (rx_q == RX_IDLE),
    .en    (body_b), // RULE8
    .din   (RXB.data),
    .crc_q (rx_crc)
  );

  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      rx_q    <= RX_IDLE;
      waddr_q <= '0;
      left_q  <= 7'h00;
      idx_q   <= 7'h00;
    end else begin
      if (we) begin
        waddr_q <= waddr_q + RXAW'(1);
      end
      unique case (rx_q)
        RX_IDLE: begin
          waddr_q <= we ? RXAW'(1) : '0;
          idx_q   <= 7'h00;
          left_q  <= RXB.data[6:0];
          if (we && RXB.data[6:0] != 7'h00) begin
            rx_q <= RX_BODY;
          end
        end
        RX_BODY: if (RXB.valid) begin
          idx_q  <= idx_q + 7'h01;
          left_q <= left_q - 7'h01;
          if (left_q == 7'h01) begin
            rx_q <= RX_LQI;
          end
        end
        RX_LQI:  rx_q <= RX_RSSI;
        RX_RSSI: rx_q <= RX_IDLE;
      endcase
    end
  end

  // header fields by byte position
  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      fcf_q   <= 16'h0000;
      seq_q   <= 8'h00;
      dpan_q  <= 16'h0000;
      daddr_q <= 16'h0000;
    end else if (body_b) begin
      unique case (idx_q)
        7'h00:   fcf_q[7:0]    <= RXB.data; // RULE14
        7'h01:   fcf_q[15:8]   <= RXB.data; // RULE14
        7'h02:   seq_q         <= RXB.data;
        7'h03:   dpan_q[7:0]   <= RXB.data;
        7'h04:   dpan_q[15:8]  <= RXB.data;
        7'h05:   daddr_q[7:0]  <= RXB.data;
        7'h06:   daddr_q[15:8] <= RXB.data;
        default: ;
      endcase
    end
  end

  // only short destination addressing is matched here
  wire logic [1:0] dam = fcf_q[`LMAC_FCF_DAM_HI:`LMAC_FCF_DAM_LO];
  wire logic crc_ok = rx_crc == 16'h0000; // RULE6
  wire logic id_ok = dam == `LMAC_DAM_SHORT &&
    (dpan_q == OWN_PAN || dpan_q == `LMAC_BCAST) &&
    (daddr_q == OWN_ADDR || daddr_q == `LMAC_BCAST);
  logic accept;

  always_comb begin
    unique case (RX_MODE)
      LMAC_RXM_NORMAL:  accept = id_ok && crc_ok; // RULE9 RULE10
      LMAC_RXM_PROMISC: accept = crc_ok; // RULE11
      LMAC_RXM_ERROR:   accept = 1'b1; // RULE12
      default:          accept = 1'b0;
    endcase
  end

  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      RX_IRQ  <= 1'b0;
      ACK_REQ <= 1'b0;
      ACK_SEQ <= 8'h00;
    end else begin
      RX_IRQ  <= rx_q == RX_RSSI && accept; // RULE10
      ACK_REQ <= rx_q == RX_RSSI && accept && crc_ok &&
                 fcf_q[`LMAC_FCF_ACKREQ]; // RULE13
      if (rx_q == RX_RSSI) begin
        ACK_SEQ <= seq_q;
      end
    end
  end

  // ==========================================
  // transmit: pass bytes, then append FCS low, high
  typedef enum logic [1:0] {TX_DATA, TX_FCS_LO, TX_FCS_HI} tx_st_t;
  tx_st_t      tx_q;
  logic [15:0] tx_crc;
  wire logic   tx_take = TXI.valid && TXI_READY;

  lmac_crc16 u_txcrc (
    .clk   (CLK),
    .rst_n (RST_N),
    .clr   (tx_q == TX_FCS_HI),
    .en    (tx_take), // RULE6
    .din   (TXI.data),
    .crc_q (tx_crc)
  );

  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      tx_q      <= TX_DATA;
      TXI_READY <= 1'b1;
      TXO       <= '0;
    end else begin
      unique case (tx_q)
        TX_DATA: begin
          TXO <= '{valid: tx_take, last: 1'b0, data: TXI.data};
          if (tx_take && TXI.last) begin
            tx_q      <= TX_FCS_LO;
            TXI_READY <= 1'b0;
          end
        end
        TX_FCS_LO: begin
          TXO  <= '{valid: 1'b1, last: 1'b0, data: tx_crc[7:0]}; // RULE5
          tx_q <= TX_FCS_HI;
        end
        TX_FCS_HI: begin
          TXO       <= '{valid: 1'b1, last: 1'b1,
                         data: tx_crc[15:8]}; // RULE5
          tx_q      <= TX_DATA;
          TXI_READY <= 1'b1;
        end
      endcase
    end
  end

  // ==========================================
  // superframe: 16 slots, CAP then optional CFP
  logic [4:0] slot_q;
  // a CAP shorter than eight slots is forced up to eight
  wire logic [3:0] cap_end = SF_CAP_END < `LMAC_MIN_CAP_END ?
                             `LMAC_MIN_CAP_END : SF_CAP_END; // RULE20

  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      slot_q        <= 5'h00;
      SF_PERIOD     <= LMAC_PER_INACT;
      TX_FIFO_SEL   <= LMAC_FIFO_NORMAL;
      CSMA_EN       <= 1'b1;
      BACKOFF_ALIGN <= 1'b0;
    end else begin
      BACKOFF_ALIGN <= 1'b0;
      if (SF_BEACON) begin
        slot_q      <= 5'h00;
        SF_PERIOD   <= LMAC_PER_BEACON;
        TX_FIFO_SEL <= LMAC_FIFO_BEACON; // RULE7
        CSMA_EN     <= 1'b0;
      end else if (SF_SLOT_TICK && SF_PERIOD != LMAC_PER_INACT) begin
        slot_q <= slot_q + 5'h01;
        if (slot_q + 5'h01 >= `LMAC_NSLOT) begin
          SF_PERIOD   <= LMAC_PER_INACT; // RULE20
          TX_FIFO_SEL <= LMAC_FIFO_NORMAL;
          CSMA_EN     <= 1'b1;
        end else if (slot_q[3:0] < cap_end ||
                     SF_PERIOD == LMAC_PER_BEACON) begin
          SF_PERIOD     <= LMAC_PER_CAP;
          TX_FIFO_SEL   <= LMAC_FIFO_NORMAL; // RULE7
          CSMA_EN       <= 1'b1;
          BACKOFF_ALIGN <= 1'b1; // RULE21
        end else begin
          SF_PERIOD   <= LMAC_PER_CFP;
          TX_FIFO_SEL <= slot_q[3:0] + 4'h1 >= SF_GTS2_START ?
                         LMAC_FIFO_GTS2 : LMAC_FIFO_GTS1; // RULE7
          CSMA_EN     <= 1'b0; // RULE22
        end
      end
    end
  end

  // ==========================================
  // assertions
  property p_load;
    @(posedge CLK) disable iff (!RST_N)
    wr_hi |=> trun_q && tcnt_q == {$past(REG_REQ.wdata), $past(tmr_lo_q)};
  endproperty
  a_load: assert property (p_load) // RULE23
    else $error("timer not loaded on high write");

  property p_irq_zero;
    @(posedge CLK) disable iff (!RST_N)
    HSYM_IRQ |-> !trun_q && tcnt_q == 16'h0000;
  endproperty
  a_irq_zero: assert property (p_irq_zero) // RULE17
    else $error("timer irq without zero");

  property p_tick;
    @(posedge CLK) disable iff (!RST_N)
    trun_q && !wr_hi && tcnt_q > 16'h0001 && tick |=>
      tcnt_q == $past(tcnt_q) - 16'h0001;
  endproperty
  a_tick: assert property (p_tick) else $error("bad timer step"); // RULE15

  property p_cca_cs;
    @(posedge CLK) disable iff (!RST_N)
    cca_mode == `LMAC_CCA_CS |=> CCA_BUSY == $past(cs_busy);
  endproperty
  a_cca_cs: assert property (p_cca_cs) else $error("cs cca wrong"); // RULE2

  property p_cca_both;
    @(posedge CLK) disable iff (!RST_N)
    cca_mode == `LMAC_CCA_BOTH && ed_busy |=> CCA_BUSY;
  endproperty
  a_cca_both: assert property (p_cca_both) // RULE4
    else $error("combined cca missed energy");

  property p_normal;
    @(posedge CLK) disable iff (!RST_N)
    RX_IRQ && $past(RX_MODE) == LMAC_RXM_NORMAL |->
      $past(id_ok) && $past(crc_ok);
  endproperty
  a_normal: assert property (p_normal) // RULE9
    else $error("normal mode took bad frame");

  property p_promisc;
    @(posedge CLK) disable iff (!RST_N)
    rx_q == RX_RSSI && RX_MODE == LMAC_RXM_PROMISC |=> RX_IRQ == $past(crc_ok);
  endproperty
  a_promisc: assert property (p_promisc) // RULE11
    else $error("promiscuous filter wrong");

  property p_ack;
    @(posedge CLK) disable iff (!RST_N)
    ACK_REQ |-> RX_IRQ && $past(fcf_q[`LMAC_FCF_ACKREQ]);
  endproperty
  a_ack: assert property (p_ack) else $error("ack without request"); // RULE13

  property p_fcs;
    @(posedge CLK) disable iff (!RST_N)
    tx_take && TXI.last |=> ##1 TXO.valid && !TXO.last ##1 TXO.valid && TXO.last;
  endproperty
  a_fcs: assert property (p_fcs) else $error("fcs not appended"); // RULE5

  property p_gts;
    @(posedge CLK) disable iff (!RST_N)
    SF_PERIOD == LMAC_PER_CFP |-> !CSMA_EN;
  endproperty
  a_gts: assert property (p_gts) else $error("csma in cfp"); // RULE22

  c_irq: cover property (@(posedge CLK) HSYM_IRQ);
  c_rx:  cover property (@(posedge CLK) RX_IRQ && ACK_REQ);
  c_tx:  cover property (@(posedge CLK) TXO.valid && TXO.last);
  c_cfp: cover property (@(posedge CLK) SF_PERIOD == LMAC_PER_CFP);
endmodule
`default_nettype wire

// File: bench/lmac_bb_model.sv
/*
  Baseband receive model: streams one frame per call of send.
  Assumes the caller starts on a falling edge of clk.
*/
`timescale 1ns/1ps
`default_nettype none
module lmac_bb_model import lmac_pkg::*; (
  // clock
  input  wire logic       clk,
  // receive stream and metrics
  output var  lmac_byte_t rxb,
  output var  logic       sof,
  output var  logic [7:0] lqi,
  output var  logic [7:0] rssi
);
  assign lqi  = 8'h3C;
  assign rssi = 8'hC3;
  initial begin
    rxb = '{1'b0, 1'b0, 8'hA5};
    sof = 1'b0;
  end
  // ====
  // frame stream
  task send(input logic [7:0] b [16], input int n);
    for (int i = 0; i <= n; i++) begin
      rxb <= '{1'b1, 1'b0, b[i]};
      sof <= (i == 0);
      @(negedge clk);
    end
    // released line shows the inverse, never a held byte
    rxb <= '{1'b0, 1'b0, ~b[n]};
    sof <= 1'b0;
    repeat (4) @(negedge clk);
  endtask
endmodule
`default_nettype wire

// File: bench/tb_top.sv
/*
  Lower MAC bench: registers, CCA, timer, receive filter, transmit
  FCS and superframe sequencing.
  Assumes the design files and lmac_bb_model are compiled first.
*/
`timescale 1ns/1ps
`default_nettype none
module tb_top import lmac_pkg::*;;
  logic          clk, rst_n, sof, rx_irq, ack, txr, cca, csma;
  logic          bal, hs, sfb, sft;
  logic [7:0]    rdata, lqi, rssi, raddr, bdata, aseq;
  logic [3:0]    csl;
  logic [7:0]    edl;
  lmac_reg_req_t req;
  lmac_byte_t    rxb, txi, txo;
  lmac_rxmode_t  mode;
  lmac_period_t  per;
  lmac_fifo_t    fsel;
  int            err_count = 0, checked = 0, nirq = 0, nack = 0;
  int            nhs = 0, cyc = 0, hs_cyc = 0;
  logic [8:0]    txq [$];
  logic [7:0]    fr [16];
  // {exp, mode, cs level, ed level}
  logic [19:0]   ccat [8] = '{20'h11F00, 20'h010FF, 20'h120FF,
    20'h02F00, 20'h13F00, 20'h130FF, 20'h03000, 20'h00FFF};
  // {mode, foreign dst, bad fcs, irq, ack}
  logic [5:0]    rxt [5] = '{6'h03, 6'h04, 6'h08, 6'h1A, 6'h26};
  // {buffer address, byte}
  logic [15:0]   bft [5] = '{16'h000A, 16'h0121, 16'h035A,
    16'h0B3C, 16'h0CC3};

  lmac_top i_lmac_top (.CLK(clk), .RST_N(rst_n), .REG_REQ(req),
    .REG_RDATA(rdata), .RXB(rxb), .RXB_SOF(sof), .RXB_LQI(lqi),
    .RXB_RSSI(rssi), .CS_LEVEL(csl), .ED_LEVEL(edl), .CCA_BUSY(cca),
    .RX_MODE(mode), .OWN_PAN(16'h1234), .OWN_ADDR(16'hBEEF),
    .RXBUF_RADDR(raddr), .RXBUF_RDATA(bdata), .RX_IRQ(rx_irq),
    .ACK_REQ(ack), .ACK_SEQ(aseq), .TXI(txi), .TXI_READY(txr),
    .TXO(txo), .SF_BEACON(sfb), .SF_SLOT_TICK(sft),
    .SF_CAP_END(4'h9), .SF_GTS2_START(4'hC), .SF_PERIOD(per),
    .TX_FIFO_SEL(fsel), .CSMA_EN(csma), .BACKOFF_ALIGN(bal),
    .HSYM_IRQ(hs));
  lmac_bb_model i_lmac_bb_model (.clk(clk), .rxb(rxb), .sof(sof),
    .lqi(lqi), .rssi(rssi));

  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end
  // ====
  // monitors: pulses are counted, so no edge race on sampling
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (rx_irq === 1'b1)
      nirq <= nirq + 1;
    if (ack === 1'b1)
      nack <= nack + 1;
    if (hs === 1'b1) begin
      nhs <= nhs + 1;
      hs_cyc <= cyc;
    end
    if (txo.valid === 1'b1)
      txq.push_back({txo.last, txo.data});
  end
  // ====
  // tasks
  task chk(input string n, input logic [15:0] g, input logic [15:0] e);
    checked++;
    if (g !== e) begin
      err_count++;
      $display("CHECK FAILED %s expected %h seen %h", n, e, g);
    end
  endtask
  task close_out;
    $display("checks %0d mismatches %0d", checked, err_count);
    if (err_count == 0 && checked > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask
  task wr(input logic [5:0] a, input logic [7:0] d);
    req <= '{1'b1, 1'b0, a, d};
    @(negedge clk);
    req <= '0;
    @(negedge clk);
  endtask
  task rchk(input string n, input logic [5:0] a, input logic [7:0] e);
    logic [7:0] v;
    req <= '{1'b0, 1'b1, a, 8'h00};
    @(negedge clk);
    v = rdata;
    req <= '0;
    @(negedge clk);
    chk(n, v, e);
  endtask
  task tx(input logic l, input logic [7:0] b);
    txi <= '{1'b1, l, b};
    for (int w = 0; w < 20 && txr !== 1'b1; w++)
      @(negedge clk);
    @(negedge clk);
  endtask
  function automatic logic [15:0] crc(input logic [15:0] c,
                                      input logic [7:0]  d);
    for (int k = 0; k < 8; k++)
      c = (c[0] ^ d[k]) ? (c >> 1) ^ 16'h8408 : c >> 1;
    return c;
  endfunction
  task mk(input logic [15:0] dst, input logic bad);
    logic [15:0] c;
    c = 16'h0000;
    fr = '{8'h0A, 8'h21, 8'h08, 8'h5A, 8'h34, 8'h12, dst[7:0],
      dst[15:8], 8'h77, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00};
    for (int i = 1; i < 9; i++)
      c = crc(c, fr[i]);
    fr[9] = c[7:0];
    fr[10] = c[15:8] ^ {7'h00, bad};
  endtask
  // ====
  // tests
  initial begin
    logic [15:0] c;
    int          n0, a0, t0;
    rst_n = 1'b0;
    req = '0;
    txi = '0;
    sfb = 1'b0;
    sft = 1'b0;
    csl = 4'h0;
    edl = 8'h00;
    raddr = 8'h00;
    mode = LMAC_RXM_NORMAL;
    repeat (12) @(negedge clk);
    chk("reset_state", {txr, per, fsel, csma, hs}, 7'h76);
    rst_n = 1'b1;
    @(negedge clk);
    rchk("tmr_lo", 6'h28, 8'h00);
    rchk("tmr_hi", 6'h29, 8'h00);
    rchk("cca_ctl", 6'h3A, 8'h78);
    rchk("unmapped", 6'h01, 8'h00);
    wr(6'h3F, 8'h40);
    rchk("ed_thr", 6'h3F, 8'h40);
    $display("test registers done");
    foreach (ccat[i]) begin
      wr(6'h3A, {ccat[i][13:12], 4'hE, 2'h0});
      csl <= ccat[i][11:8];
      edl <= ccat[i][7:0];
      repeat (3) @(negedge clk);
      chk("cca_busy", cca, ccat[i][16]);
    end
    $display("test cca done");
    // two ticks proves the stored low byte reaches the count
    wr(6'h28, 8'h02);
    t0 = cyc;
    wr(6'h29, 8'h00);
    for (int w = 0; w < 3400 && nhs == 0; w++)
      @(negedge clk);
    chk("tmr_span", (hs_cyc - t0) inside {[3199:3204]}, 1);
    repeat (1700) @(negedge clk);
    chk("tmr_irqs", 16'(nhs), 16'h0001);
    rchk("tmr_lo_rw", 6'h28, 8'h02);
    // beacon-interval base, far too long to run out here
    wr(6'h28, 8'h80);
    wr(6'h29, 8'h07);
    rchk("tmr_live_hi", 6'h29, 8'h07);
    rchk("tmr_live_lo", 6'h28, 8'h80);
    $display("test timer done");
    for (int i = 0; i < 5; i++) begin
      mode <= lmac_rxmode_t'(rxt[i][5:4]);
      mk(rxt[i][3] ? 16'h0001 : 16'hBEEF, rxt[i][2]);
      n0 = nirq;
      a0 = nack;
      i_lmac_bb_model.send(fr, 10);
      chk("rx_irq", 16'(nirq - n0), rxt[i][1]);
      if (rxt[i][5:4] != 2'h1)
        chk("ack_req", 16'(nack - a0), rxt[i][0]);
    end
    chk("ack_seq", aseq, 8'h5A);
    foreach (bft[i]) begin
      raddr <= bft[i][15:8];
      @(negedge clk);
      chk("rxbuf", bdata, bft[i][7:0]);
    end
    $display("test receive done");
    tx(1'b0, 8'h11);
    tx(1'b1, 8'h22);
    txi <= '{1'b0, 1'b0, 8'hDD};
    repeat (6) @(negedge clk);
    c = crc(crc(16'h0000, 8'h11), 8'h22);
    chk("tx_bytes", 16'(txq.size()), 16'h0004);
    chk("tx_b0", txq[0], 9'h011);
    chk("tx_b1", txq[1], 9'h022);
    chk("tx_fcs_lo", txq[2], {1'b0, c[7:0]});
    chk("tx_fcs_hi", txq[3], {1'b1, c[15:8]});
    $display("test transmit done");
    sfb <= 1'b1;
    @(negedge clk);
    sfb <= 1'b0;
    @(negedge clk);
    chk("sf_beacon", {per, fsel}, 4'h0);
    for (int k = 1; k <= 16; k++) begin
      sft <= 1'b1;
      @(negedge clk);
      sft <= 1'b0;
      case (k)
        1, 8: chk("sf_cap", {bal, per, fsel, csma}, 6'h2B);
        10: chk("sf_gts1", {bal, per, fsel, csma}, 6'h14);
        13: chk("sf_gts2", {bal, per, fsel, csma}, 6'h16);
        16: chk("sf_inact", per, 2'h3);
        default: ;
      endcase
      @(negedge clk);
    end
    $display("test superframe done");
    close_out();
  end
  initial begin
    #100us;
    err_count++;
    $display("watchdog expired");
    close_out();
  end
endmodule
`default_nettype wire
